//--- uart_async_rx_recovery_tb.sv
`timescale 1ns/100ps
module uart_async_rx_recovery_tb;
  import uarx_pkg::*;
  typedef struct packed {
    logic dbl; logic [15:0] div; logic [3:0] nb; logic [9:0] d; logic stp; logic [3:0] g;
  } uarx_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic doubleSpeedSelect = 1'b0;
  logic [15:0] baudDividerValue = 16'h0000;
  logic [3:0] frameBits = 4'h8;
  logic serialRxLine;
  logic frameValid;
  uarx_frame_t frameOut;
  int fail_count = 0;
  int cmp_count = 0;
  uarx_row_t rows [7] = '{'{0, 0, 8, 10'h0a5, 1, 15}, '{1, 0, 8, 10'h05a, 1, 15},
    '{0, 3, 5, 10'h015, 1, 15}, '{1, 1, 10, 10'h2c3, 1, 15}, '{0, 1, 10, 10'h3ff, 0, 15},
    '{0, 0, 8, 10'h0ff, 1, 3}, '{1, 2, 7, 10'h055, 1, 0}};
  always #5 ref_clk = ~ref_clk;
  uarx_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .serialRxLine(serialRxLine),
    .doubleSpeedSelect(doubleSpeedSelect), .baudDividerValue(baudDividerValue),
    .frameBits(frameBits), .frameValid(frameValid), .frameOut(frameOut));
  uarx_tx_model u_tx (.ref_clk(ref_clk), .serialRxLine(serialRxLine));
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic grab(input logic [10:0] exp);
    int n;
    n = 0;
    while (frameValid !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20000) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, 11'h7ff, exp);
    end
    cmp(frameOut, exp);
    @(negedge ref_clk);
  endtask : grab
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  initial begin
    #300000;
    fail_count++;
    stop_test();
  end
  initial begin
    int s;
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    cmp({frameOut[9:0], frameValid}, 11'h000);
    foreach (rows[i]) begin
      doubleSpeedSelect = rows[i].dbl;
      baudDividerValue = rows[i].div;
      frameBits = rows[i].nb;
      s = (rows[i].dbl ? 8 : 16) * (rows[i].div + 1);
      repeat (s) @(negedge ref_clk);
      fork
        u_tx.send(rows[i].d, rows[i].nb, rows[i].stp, s, s, rows[i].g);
        grab({rows[i].d, ~rows[i].stp});
      join
    end
    doubleSpeedSelect = 1'b0;
    baudDividerValue = 16'h0000;
    frameBits = 4'h8;
    repeat (20) @(negedge ref_clk);
    u_tx.noise(6);
    repeat (20) @(negedge ref_clk);
    fork
      u_tx.send(10'h03c, 8, 1'b1, 16, 16, 15);
      grab({10'h03c, 1'b0});
    join
    fork
      begin
        u_tx.send(10'h096, 8, 1'b1, 16, 11, 15);
        u_tx.send(10'h069, 8, 1'b1, 16, 16, 15);
      end
      begin
        grab({10'h096, 1'b0});
        grab({10'h069, 1'b0});
      end
    join
    rst_n = 1'b0;
    @(negedge ref_clk);
    cmp(frameOut, 11'h000);
    rst_n = 1'b1;
    stop_test();
  end
endmodule : uart_async_rx_recovery_tb

//--- uarx_chk_sva.sv
`timescale 1ns/100ps
module uarx_chk (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  serialRxLine,
  input wire logic                  doubleSpeedSelect,
  input wire logic [15:0]           baudDividerValue,
  input wire logic [3:0]            frameBits,
  input wire logic                  frameValid,
  input wire uarx_pkg::uarx_frame_t frameOut
);
  import uarx_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ====
  // helpers: idle-high run and clocks since last frame
  logic [9:0] hiRun;
  logic [6:0] gap;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hiRun <= 10'h000;
      gap <= 7'h7f;
    end else begin
      hiRun <= !serialRxLine ? 10'h000 : hiRun + {9'h000, hiRun != 10'h3ff};
      gap <= frameValid ? 7'h00 : gap + {6'h00, gap != 7'h7f};
    end
  end
  property p_pulse; frameValid |=> !frameValid; endproperty
  a_pulse: assert property (p_pulse) else $error("frame pulse too long");
  property p_hold; !$stable(frameOut) |-> frameValid; endproperty
  a_hold: assert property (p_hold) else $error("frame changed alone");
  property p_upper; frameValid && frameBits >= 4'h5 && frameBits <= 4'ha
    |-> (frameOut.data >> frameBits) == 10'h000; endproperty
  a_upper: assert property (p_upper) else $error("bits above length");
  property p_ferr; frameValid |-> frameOut.frameErrorFlag == !$past(serialRxLine, 5); endproperty
  a_ferr: assert property (p_ferr) else $error("frame error flag wrong");
  property p_rst; $rose(rst_n) |-> frameOut == '0 && !frameValid; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  property p_early; $rose(rst_n) |-> !frameValid [*8]; endproperty
  a_early: assert property (p_early) else $error("frame right after reset");
  property p_idle; frameValid |-> hiRun < 10'd800; endproperty
  a_idle: assert property (p_idle) else $error("frame without start");
  property p_gap; frameValid |-> gap >= 7'd40; endproperty
  a_gap: assert property (p_gap) else $error("frames too close");
endmodule : uarx_chk
bind uarx_core uarx_chk u_chk (.ref_clk, .rst_n, .serialRxLine, .doubleSpeedSelect,
  .baudDividerValue, .frameBits, .frameValid, .frameOut);

//--- uarx_core.sv
`timescale 1ns/100ps
module uarx_core (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 serialRxLine,
  input  wire logic                 doubleSpeedSelect,
  input  wire logic [15:0]          baudDividerValue,
  input  wire logic [3:0]           frameBits,
  output logic                      frameValid,
  output uarx_pkg::uarx_frame_t     frameOut
);
  import uarx_pkg::*;

  // ===================================================
  // synchroniser
  logic lineMeta, lineSync, linePrev;
  logic next_lineMeta, next_lineSync, next_linePrev;

  always_comb begin
    next_lineMeta = serialRxLine;
    next_lineSync = lineMeta;
    next_linePrev = lineSync;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineMeta <= 1'b1;
      lineSync <= 1'b1;
      linePrev <= 1'b1;
    end else begin
      lineMeta <= next_lineMeta;
      lineSync <= next_lineSync;
      linePrev <= next_linePrev;
    end
  end

  // ===================================================
  // sample tick from baud divider
  logic [15:0] divCount, next_divCount;
  logic        tick;

  always_comb begin
    tick          = (divCount == DIV_ZERO);
    next_divCount = tick ? baudDividerValue : divCount - DIV_ONE;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCount <= DIV_ZERO;
    end else begin
      divCount <= next_divCount;
    end
  end

  // ===================================================
  // recovery state: shared declarations
  uarx_state_t state;
  uarx_state_t next_state;
  logic [3:0]  sampleIdx;
  logic [3:0]  next_sampleIdx;
  logic [3:0]  bitCount;
  logic [3:0]  next_bitCount;
  logic [2:0]  votes;
  logic [2:0]  next_votes;
  logic [9:0]  shiftReg;
  logic [9:0]  next_shiftReg;
  logic        next_frameValid;
  uarx_frame_t next_frameOut;
  logic        lastSample;
  logic        next_lastSample;
  logic        dblHeld;
  logic        next_dblHeld;
  logic [3:0]  lenHeld;
  logic [3:0]  next_lenHeld;
  logic [3:0]  lastIdx;
  logic [3:0]  midIdx;
  logic        busy;
  logic        inCentre;
  logic        voteTick;
  logic        startSeen;
  logic        bitVal;

  // ===================================================
  // helpers
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  // wrap after the last sample state of a bit
  function automatic logic [3:0] stepIdx(input logic [3:0] idx, input logic [3:0] last);
    stepIdx = (idx == last) ? ZERO4 : idx + ONE4;
  endfunction : stepIdx

  // out-of-range lengths are held to the nearest supported size
  function automatic logic [3:0] clampLen(input logic [3:0] n);
    clampLen = (n < LEN_W_MIN) ? LEN_W_MIN : (n > LEN_W_MAX) ? LEN_W_MAX : n;
  endfunction : clampLen

  // ===================================================
  // start hunt on the tick grid
  always_comb begin
    next_lastSample = tick ? lineSync : lastSample;
    // a high sample then a low one; a line held low never restarts
    startSeen       = tick && lastSample && !lineSync && (state == UARX_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastSample <= 1'b1;
    end else begin
      lastSample <= next_lastSample;
    end
  end

  // ===================================================
  // speed select and length, held for the whole frame; the baud divider is not held
  // a mid-frame change of speed or length would tear the bit grid
  always_comb begin
    next_dblHeld = dblHeld;
    next_lenHeld = lenHeld;
    if (startSeen) begin
      next_dblHeld = doubleSpeedSelect;
      next_lenHeld = clampLen(frameBits);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dblHeld <= 1'b0;
      lenHeld <= LEN_W_MAX;
    end else begin
      dblHeld <= next_dblHeld;
      lenHeld <= next_lenHeld;
    end
  end

  // ===================================================
  // sample position decode
  always_comb begin
    // samples per bit set by speed select
    lastIdx  = dblHeld ? LAST_DOUBLE : LAST_NORMAL;
    midIdx   = dblHeld ? MID_DOUBLE : MID_NORMAL;
    // sample number equals sampleIdx; the last sample of a bit wraps to zero
    busy     = (state != UARX_IDLE);
    inCentre = busy && tick && (sampleIdx >= midIdx - ONE4) && (sampleIdx <= midIdx + ONE4);
    voteTick = busy && tick && (sampleIdx == midIdx + ONE4);
    bitVal   = vote3({votes[1:0], lineSync});
  end

  // ===================================================
  // bit timing state machine
  always_comb begin
    next_state     = state;
    next_sampleIdx = sampleIdx;
    next_bitCount  = bitCount;
    if (busy && tick) begin
      next_sampleIdx = stepIdx(sampleIdx, lastIdx);
    end
    case (state)
      UARX_IDLE: begin
        // first low sample is sample one
        if (startSeen) begin
          next_state     = UARX_START;
          next_sampleIdx = ONE4;
        end
      end
      UARX_START: begin
        if (voteTick) begin
          if (bitVal) begin
            next_state     = UARX_IDLE;
            next_sampleIdx = ZERO4;
          end else begin
            next_state    = UARX_BITS;
            next_bitCount = ZERO4;
          end
        end
      end
      UARX_BITS: begin
        if (voteTick) begin
          next_bitCount = bitCount + ONE4;
          if (bitCount + ONE4 == lenHeld) begin
            next_state = UARX_STOP;
          end
        end
      end
      UARX_STOP: begin
        if (voteTick) begin
          // later stops ignored, hunt resumes at once
          next_state     = UARX_IDLE;
          next_sampleIdx = ZERO4;
        end
      end
      default: begin
        next_state = UARX_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= UARX_IDLE;
      sampleIdx <= ZERO4;
      bitCount  <= ZERO4;
    end else begin
      state     <= next_state;
      sampleIdx <= next_sampleIdx;
      bitCount  <= next_bitCount;
    end
  end

  // ===================================================
  // centre vote samples
  always_comb begin
    next_votes = votes;
    if (startSeen) begin
      next_votes = '0;
    end else if (inCentre) begin
      next_votes = {votes[1:0], lineSync};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      votes <= '0;
    end else begin
      votes <= next_votes;
    end
  end

  // ===================================================
  // data shift register
  always_comb begin
    next_shiftReg = shiftReg;
    // lsb first, newest bit enters at the top
    if (voteTick && state == UARX_BITS) begin
      next_shiftReg = {bitVal, shiftReg[9:1]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= '0;
    end else begin
      shiftReg <= next_shiftReg;
    end
  end

  // ===================================================
  // frame result
  // result holds until the next frame; there is no buffer behind it
  always_comb begin
    next_frameValid = 1'b0;
    next_frameOut   = frameOut;
    if (voteTick && state == UARX_STOP) begin
      // stop vote of zero flags a frame error
      next_frameOut.frameErrorFlag = ~bitVal;
      // data right-justified: drop the unused low slots of the shifter
      next_frameOut.data           = shiftReg >> (4'(MAX_BITS) - lenHeld);
      next_frameValid              = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameValid <= 1'b0;
      frameOut   <= '0;
    end else begin
      frameValid <= next_frameValid;
      frameOut   <= next_frameOut;
    end
  end

endmodule : uarx_core

//--- uarx_pkg.sv
package uarx_pkg;

  // =====================================================
  // frame sizing
  localparam int unsigned MAX_BITS    = 10;
  localparam int unsigned MIN_BITS    = 5;
  localparam logic [3:0]  LEN_W_MIN   = 4'h5;
  localparam logic [3:0]  LEN_W_MAX   = 4'ha;

  // =====================================================
  // sample indices (samples counted from 1)
  localparam logic [3:0]  LAST_NORMAL = 4'hf;   // samples 1..15, the sixteenth wraps to 0
  localparam logic [3:0]  LAST_DOUBLE = 4'h7;   // samples 1..7, the eighth wraps to 0
  localparam logic [3:0]  MID_NORMAL  = 4'h9;   // centre samples 8,9,10
  localparam logic [3:0]  MID_DOUBLE  = 4'h5;   // centre samples 4,5,6
  localparam logic [3:0]  ONE4        = 4'h1;
  localparam logic [3:0]  ZERO4       = 4'h0;
  localparam logic [15:0] DIV_ZERO    = 16'h0000;
  localparam logic [15:0] DIV_ONE     = 16'h0001;

  typedef enum logic [1:0] {
    UARX_IDLE  = 2'b00,
    UARX_START = 2'b01,
    UARX_BITS  = 2'b10,
    UARX_STOP  = 2'b11
  } uarx_state_t;

  typedef struct packed {
    logic [9:0] data;
    logic       frameErrorFlag;
  } uarx_frame_t;

endpackage : uarx_pkg

//--- uarx_tx_model.sv
`timescale 1ns/100ps
module uarx_tx_model (
  input wire logic ref_clk,
  output logic     serialRxLine
);
  initial serialRxLine = 1'b1;
  // ====
  // exact bit rate, no drift
  task automatic send(input logic [9:0] d, input int nb, input logic stp, input int spb,
                      input int stopLen, input int g);
    for (int i = -1; i <= nb; i++) begin
      for (int c = 0; c < ((i == nb) ? stopLen : spb); c++) begin
        @(negedge ref_clk);
        serialRxLine <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i] ^ (i == g && c == spb / 2);
      end
    end
    @(negedge ref_clk);
    serialRxLine <= 1'b1;
  endtask : send
  task automatic noise(input int n);
    repeat (n) @(negedge ref_clk) serialRxLine <= 1'b0;
    @(negedge ref_clk) serialRxLine <= 1'b1;
  endtask : noise
endmodule : uarx_tx_model
